/* File: hdl/mem_taker_end.sv */
`timescale 1ns/1ps
`include "stall_defs.svh"

module mem_taker_end
	import stall_pkg::*;
#(
	parameter bit USE_BUS_FREE = 1'b1,
	parameter bit USE_FETCH = 1'b0,
	parameter int REF_STALL = `REF_STALL_CYC,
	parameter addr_t SLOW_BASE = `SLOW_BASE,
	parameter addr_t SLOW_MASK = `SLOW_MASK
)
(
	input wire logic clk,           // System clock
	input wire logic reset_n,       // Synchronous reset
	mem_stall_if.taker bus,         // Memory side
	input wire logic dma_req,       // DMA wants the bus, level
	input wire addr_t dma_addr,     // DMA address
	input wire logic dma_write,     // DMA transfer writes memory
	input wire data_t dma_wdata,    // DMA write data
	output logic dma_grant,         // Bus held for DMA
	output data_t dma_rdata,        // DMA read data
	output logic dma_done,          // One DMA transfer finished
	output logic [`ROW_W-1:0] row,  // Next row to refresh
	output logic refreshing         // Refresh cycle in progress
);

	// ****************************************************************
	// Refresh timer
	// ****************************************************************
	// Counts processor cycles, so 64 cycles at 1 MHz gives about 64 us
	logic [`REF_TICK_W-1:0] tick_r, tick_nxt;
	logic pend_r, pend_nxt;
	logic [`ROW_W-1:0] row_r, row_nxt;
	logic ref_fin;

	always_comb
	begin
		tick_nxt = tick_r;
		pend_nxt = pend_r;
		row_nxt = row_r;
		if (ref_fin)
		begin
			pend_nxt = 1'b0;
			row_nxt = row_r + `ROW_W'(1);
		end
		if (bus.cyc_end)
		begin
			tick_nxt = tick_r + `REF_TICK_W'(1);
			if (tick_r == `REF_TICK_LAST)
				pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			tick_r <= 6'h00;
			pend_r <= 1'b0;
			row_r <= 5'h00;
		end
		else
		begin
			tick_r <= tick_nxt;
			pend_r <= pend_nxt;
			row_r <= row_nxt;
		end
	end

	// ****************************************************************
	// Bus takeover
	// ****************************************************************
	taker_st_t st_r, st_nxt;
	logic ref_r, ref_nxt;
	logic seen_r, seen_nxt;
	logic [7:0] left_r, left_nxt;
	logic waited_r, waited_nxt;
	data_t drd_r, drd_nxt;
	logic done_r, done_nxt;
	logic stop_now, own, slow_stall;

	// Stop seen: bus-free, or a read seen in phase two
	assign stop_now = USE_BUS_FREE ? bus.bus_free : (bus.ph2 && bus.cpu_rw == `RW_READ);
	// Early half cycle of the stop cycle is lost, giving N - 1/2
	assign own = (st_r == TK_OWN) || (st_r == TK_WAIT && seen_r);
	assign slow_stall = (st_r == TK_IDLE) && ((bus.cpu_addr & SLOW_MASK) == SLOW_BASE)
		&& (bus.cpu_rw == `RW_READ) && !waited_r;

	always_comb
	begin
		st_nxt = st_r;
		ref_nxt = ref_r;
		seen_nxt = seen_r;
		left_nxt = left_r;
		waited_nxt = waited_r;
		drd_nxt = drd_r;
		done_nxt = 1'b0;
		ref_fin = 1'b0;
		if (st_r == TK_WAIT && stop_now)
			seen_nxt = 1'b1;
		if (bus.cyc_end)
		begin
			waited_nxt = slow_stall;
			unique case (st_r)
				TK_IDLE:
				begin
					if (USE_FETCH && pend_r && bus.fetch_mark)
					begin
						// Next cycle cannot be a write, so seize it whole
						st_nxt = TK_OWN;
						ref_nxt = 1'b1;
						left_nxt = 8'h01;
					end
					else if (!USE_FETCH && pend_r)
					begin
						st_nxt = TK_WAIT;
						ref_nxt = 1'b1;
					end
					else if (dma_req)
					begin
						st_nxt = TK_WAIT;
						ref_nxt = 1'b0;
					end
				end
				TK_WAIT:
				begin
					if (seen_r || stop_now)
					begin
						seen_nxt = 1'b0;
						if (ref_r && REF_STALL <= 1)
						begin
							// Only the half cycle was available
							st_nxt = TK_IDLE;
							ref_fin = 1'b1;
						end
						else
						begin
							st_nxt = TK_OWN;
							left_nxt = 8'(REF_STALL - 1);
						end
					end
				end
				TK_OWN:
				begin
					if (ref_r)
					begin
						left_nxt = left_r - 8'h01;
						if (left_r == 8'h01)
						begin
							st_nxt = TK_IDLE;
							ref_fin = 1'b1;
						end
					end
					else
					begin
						done_nxt = 1'b1;
						drd_nxt = bus.data_bus;
						if (!dma_req)
							st_nxt = TK_IDLE;
					end
				end
				default:
				begin
					st_nxt = TK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			st_r <= TK_IDLE;
			ref_r <= 1'b0;
			seen_r <= 1'b0;
			left_r <= 8'h00;
			waited_r <= 1'b0;
			drd_r <= 8'h00;
			done_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			ref_r <= ref_nxt;
			seen_r <= seen_nxt;
			left_r <= left_nxt;
			waited_r <= waited_nxt;
			drd_r <= drd_nxt;
			done_r <= done_nxt;
		end
	end

	// ****************************************************************
	// Selector and extender
	// ****************************************************************
	logic dma_own;

	assign dma_own = own && !ref_r;
	assign bus.run = (st_r == TK_IDLE) && !slow_stall;
	assign bus.mem_addr = !own ? bus.cpu_addr
		: (ref_r ? addr_t'(row_r) : dma_addr);
	assign bus.mem_rw = !own ? bus.cpu_rw
		: (ref_r ? `RW_READ : !dma_write);
	assign bus.ext_data_o = dma_wdata;
	assign bus.ext_data_oe = dma_own && dma_write;
	assign dma_grant = dma_own;
	assign dma_rdata = drd_r;
	assign dma_done = done_r;
	assign row = row_r;
	assign refreshing = own && ref_r;

endmodule : mem_taker_end

/* File: hdl/stall_defs.svh */
`ifndef STALL_DEFS_SVH
`define STALL_DEFS_SVH

// ****************************************************************
// Processor cycle timing
// ****************************************************************
`define CLK_PERIOD_NS 4
`define PROC_CYCLE_NS 1000
`define PROC_CYC_CLKS (`PROC_CYCLE_NS / `CLK_PERIOD_NS)

// ****************************************************************
// Bus widths
// ****************************************************************
`define ADDR_W 16
`define DATA_W 8
`define ROW_W 5

// ****************************************************************
// Refresh and slow memory
// ****************************************************************
`define REF_TICK_W 6
`define REF_TICK_LAST 6'h3f
`define REF_STALL_CYC 2
`define SLOW_BASE 16'he000
`define SLOW_MASK 16'he000
`define RW_READ 1'b1
`define RW_WRITE 1'b0

`endif

/* File: hdl/stall_pkg.sv */
`include "stall_defs.svh"

package stall_pkg;

	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [`DATA_W-1:0] data_t;

	// Taker states
	typedef enum logic [1:0]
	{
		TK_IDLE = 2'b00,
		TK_WAIT = 2'b01,
		TK_OWN = 2'b10
	} taker_st_t;

endpackage : stall_pkg

/* File: hdl/mem_stall_if.sv */
`timescale 1ns/1ps
`include "stall_defs.svh"

interface mem_stall_if;
	import stall_pkg::*;

	logic run;            // Low stalls the processor in a read cycle
	logic ph2;            // Phase two of the processor cycle
	logic cyc_end;        // Last clock of a processor cycle
	addr_t cpu_addr;      // Processor address
	logic cpu_rw;         // Processor direction, high reads
	data_t cpu_data_o;    // Processor write data
	logic cpu_data_oe;    // Processor drives data bus
	logic fetch_mark;     // Opcode fetch cycle
	logic bus_free;       // Processor has released the bus
	addr_t mem_addr;      // Selected memory address
	logic mem_rw;         // Selected memory direction
	data_t ext_data_o;    // Extender data toward memory
	logic ext_data_oe;    // Extender drives data bus
	data_t mem_rdata;     // Memory read data, from outside
	data_t data_bus;      // Resolved data bus level

	// Bus resolution; drivers never overlap when both ends behave
	assign data_bus = cpu_data_oe ? cpu_data_o : (ext_data_oe ? ext_data_o : mem_rdata);

	modport cpu
	(
		input run, data_bus,
		output ph2, cyc_end, cpu_addr, cpu_rw, cpu_data_o, cpu_data_oe, fetch_mark, bus_free
	);

	modport taker
	(
		input ph2, cyc_end, cpu_addr, cpu_rw, fetch_mark, bus_free, data_bus,
		output run, mem_addr, mem_rw, ext_data_o, ext_data_oe
	);

endinterface : mem_stall_if

/* File: hdl/cpu_stall_end.sv */
`timescale 1ns/1ps
`include "stall_defs.svh"

module cpu_stall_end
	import stall_pkg::*;
#(
	parameter int CYC_CLKS = `PROC_CYC_CLKS,
	parameter bit HAS_BUS_FREE = 1'b1
)
(
	input wire logic clk,           // System clock
	input wire logic reset_n,       // Synchronous reset
	mem_stall_if.cpu bus,           // Memory side
	input wire addr_t acc_addr,     // Next access address
	input wire logic acc_write,     // Next access is a write
	input wire data_t acc_wdata,    // Next write data
	input wire logic acc_fetch,     // Next access is an opcode fetch
	output logic acc_take,          // Next access taken this clock
	output data_t rd_data,          // Latched read data
	output logic rd_valid,          // Read data pulse
	output logic stalled            // Previous cycle was held, this one repeats it
);

	// ****************************************************************
	// Cycle sequencing
	// ****************************************************************
	logic [15:0] ph_r, ph_nxt;
	addr_t addr_r, addr_nxt;
	logic rw_r, rw_nxt;
	data_t wdata_r, wdata_nxt;
	logic fetch_r, fetch_nxt;
	logic free_r, free_nxt;
	data_t rdat_r, rdat_nxt;
	logic rval_r, rval_nxt;
	logic stall_r, stall_nxt;
	logic cyc_end, ph2, hold;

	assign cyc_end = (ph_r == 16'(CYC_CLKS - 1));
	assign ph2 = (ph_r >= 16'(CYC_CLKS / 2));
	assign hold = (rw_r == `RW_READ) && !bus.run;

	always_comb
	begin
		ph_nxt = cyc_end ? 16'h0000 : ph_r + 16'h0001;
		addr_nxt = addr_r;
		rw_nxt = rw_r;
		wdata_nxt = wdata_r;
		fetch_nxt = fetch_r;
		free_nxt = free_r;
		rdat_nxt = rdat_r;
		rval_nxt = 1'b0;
		stall_nxt = stall_r;
		acc_take = 1'b0;
		if (HAS_BUS_FREE && ph2 && hold)
			free_nxt = 1'b1;
		if (cyc_end)
		begin
			stall_nxt = hold;
			if (hold)
			begin
				// Same read repeats, nothing taken
				free_nxt = HAS_BUS_FREE;
			end
			else
			begin
				free_nxt = 1'b0;
				if (rw_r == `RW_READ)
				begin
					rdat_nxt = bus.data_bus;
					rval_nxt = 1'b1;
				end
				if (fetch_r && acc_write)
				begin
					// Write may not follow a fetch: insert a read
					rw_nxt = `RW_READ;
					fetch_nxt = 1'b0;
				end
				else
				begin
					acc_take = 1'b1;
					addr_nxt = acc_addr;
					rw_nxt = acc_write ? `RW_WRITE : `RW_READ;
					wdata_nxt = acc_wdata;
					fetch_nxt = acc_fetch && !acc_write;
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			ph_r <= 16'h0000;
			addr_r <= 16'h0000;
			rw_r <= `RW_READ;
			wdata_r <= 8'h00;
			fetch_r <= 1'b0;
			free_r <= 1'b0;
			rdat_r <= 8'h00;
			rval_r <= 1'b0;
			stall_r <= 1'b0;
		end
		else
		begin
			ph_r <= ph_nxt;
			addr_r <= addr_nxt;
			rw_r <= rw_nxt;
			wdata_r <= wdata_nxt;
			fetch_r <= fetch_nxt;
			free_r <= free_nxt;
			rdat_r <= rdat_nxt;
			rval_r <= rval_nxt;
			stall_r <= stall_nxt;
		end
	end

	// ****************************************************************
	// Bus outputs
	// ****************************************************************
	assign bus.ph2 = ph2;
	assign bus.cyc_end = cyc_end;
	assign bus.cpu_addr = addr_r;
	assign bus.cpu_rw = rw_r;
	assign bus.cpu_data_o = wdata_r;
	assign bus.cpu_data_oe = (rw_r == `RW_WRITE) && ph2;
	assign bus.fetch_mark = fetch_r;
	assign bus.bus_free = free_r;
	assign rd_data = rdat_r;
	assign rd_valid = rval_r;
	assign stalled = stall_r;

endmodule : cpu_stall_end

/* File: testbench/stall_link_properties.sv */
`timescale 1ns/1ps
`include "stall_defs.svh"

module stall_link_properties
	import stall_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic reset_n, // Sync reset
	input wire logic run, // Low stalls
	input wire logic ph2, // Phase two
	input wire logic cyc_end, // Cycle end
	input wire addr_t cpu_addr, // Cpu address
	input wire logic cpu_rw, // Cpu direction
	input wire logic cpu_data_oe, // Cpu drives data
	input wire logic fetch_mark, // Opcode fetch
	input wire logic bus_free, // Bus released
	input wire addr_t mem_addr, // Memory address
	input wire logic mem_rw, // Memory direction
	input wire logic ext_data_oe // Extender drives
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ****
	// Link properties
	// ****
	sequence seq_held;
		cyc_end && !run && cpu_rw == `RW_READ;
	endsequence
	sequence seq_release;
		$rose(run);
	endsequence

	chk_stall_hold: assert property (seq_held |=> $stable(cpu_addr) && cpu_rw == `RW_READ)
		else $error("held read moved");
	chk_wr_complete: assert property (ph2 && cpu_rw == `RW_WRITE |-> cpu_data_oe && !bus_free)
		else $error("write not driven");
	chk_bus_quiet: assert property (bus_free |-> !cpu_data_oe)
		else $error("cpu drives released bus");
	chk_free_ph2: assert property ($rose(bus_free) |-> ph2 && !run && cpu_rw == `RW_READ)
		else $error("bus free rose badly");
	chk_ext_gated: assert property (ext_data_oe |-> bus_free)
		else $error("extender on early");
	chk_sel_route: assert property (run && !bus_free |-> mem_addr == cpu_addr && mem_rw == cpu_rw)
		else $error("selector wrong");
	chk_run_back: assert property (seq_release |-> $past(cyc_end) && !ph2)
		else $error("run rose mid cycle");
	chk_fetch_read: assert property (cyc_end && fetch_mark |=> cpu_rw == `RW_READ)
		else $error("write after fetch");
endmodule : stall_link_properties

/* File: testbench/test_cpu_stall_memory_takeover.sv */
`timescale 1ns/1ps
`include "stall_defs.svh"

module test_cpu_stall_memory_takeover;
	import stall_pkg::*;

	// Short cycle keeps many refresh periods in one run
	localparam int CYC = 8;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	addr_t acc_addr = '0;
	logic acc_write = 1'b0;
	data_t acc_wdata = '0;
	logic acc_fetch = 1'b0;
	logic acc_take, rd_valid, stalled, dma_grant, dma_done, refreshing;
	data_t rd_data, dma_rdata;
	logic dma_req = 1'b0;
	addr_t dma_addr = '0;
	logic dma_write = 1'b0;
	data_t dma_wdata = '0;
	logic [`ROW_W-1:0] row;
	logic [`ROW_W-1:0] exp_row = '0;
	logic ref_prev = 1'b0;
	// Last access taken, so the read inserted after a fetch can be expected
	logic prev_fetch = 1'b0;
	addr_t prev_addr = '0;
	data_t rq[$], wq[$], dq[$];
	int err_total = 0, num_checks = 0, clk_cnt = 0, cyc_cnt = 0, n_ref = 0;

	function automatic data_t mem_f(input addr_t a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : mem_f

	mem_stall_if bus ();
	assign bus.mem_rdata = mem_f(bus.mem_addr);

	cpu_stall_end #(.CYC_CLKS(CYC), .HAS_BUS_FREE(1'b1)) u_cpu_stall_end (.clk(clk), .reset_n(reset_n),
		.bus(bus.cpu), .acc_addr(acc_addr), .acc_write(acc_write), .acc_wdata(acc_wdata), .acc_fetch(acc_fetch),
		.acc_take(acc_take), .rd_data(rd_data), .rd_valid(rd_valid), .stalled(stalled));
	mem_taker_end #(.USE_BUS_FREE(1'b1), .USE_FETCH(1'b0)) u_mem_taker_end (.clk(clk), .reset_n(reset_n),
		.bus(bus.taker), .dma_req(dma_req), .dma_addr(dma_addr), .dma_write(dma_write), .dma_wdata(dma_wdata),
		.dma_grant(dma_grant), .dma_rdata(dma_rdata), .dma_done(dma_done), .row(row), .refreshing(refreshing));
	stall_link_properties u_stall_link_properties (.clk(clk), .reset_n(reset_n), .run(bus.run), .ph2(bus.ph2),
		.cyc_end(bus.cyc_end), .cpu_addr(bus.cpu_addr), .cpu_rw(bus.cpu_rw), .cpu_data_oe(bus.cpu_data_oe),
		.fetch_mark(bus.fetch_mark), .bus_free(bus.bus_free), .mem_addr(bus.mem_addr), .mem_rw(bus.mem_rw),
		.ext_data_oe(bus.ext_data_oe));

	// ****
	// Tasks
	// ****
	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task test_done();
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// Holds the access until acc_take is seen ahead of the taking edge
	task cpu_acc(input addr_t a, input logic w, input logic f, output int t);
		int n;
		@(negedge clk);
		acc_addr = a;
		acc_write = w;
		acc_fetch = f;
		acc_wdata = data_t'($urandom);
		n = 0;
		#1;
		while (acc_take !== 1'b1 && n < 16 * CYC)
		begin
			@(negedge clk);
			#1;
			n++;
		end
		t = clk_cnt;
		// A write after a fetch is deferred behind a repeat read of the fetch address
		if (w && prev_fetch)
			rq.push_back(mem_f(prev_addr));
		if (w)
			wq.push_back(acc_wdata);
		else
			rq.push_back(mem_f(a));
		prev_fetch = f && !w;
		prev_addr = a;
	endtask : cpu_acc

	task cpu_run();
		int t;
		logic w, f;
		f = 1'b0;
		repeat (2200)
		begin
			w = ($urandom_range(3) == 0) && !f;
			f = !w && ($urandom_range(2) == 0);
			cpu_acc(addr_t'($urandom), w, f, t);
		end
	endtask : cpu_run

	task dma_run();
		int k, n;
		repeat (40)
		begin
			repeat ($urandom_range(300, 20)) @(negedge clk);
			k = $urandom_range(4, 2);
			dma_addr = addr_t'($urandom);
			dma_write = 1'($urandom);
			dma_wdata = data_t'($urandom);
			dma_req = 1'b1;
			repeat (k) dq.push_back(dma_write ? dma_wdata : mem_f(dma_addr));
			for (int i = 0; i < k; i++)
			begin
				n = 0;
				do
				begin
					@(negedge clk);
					n++;
				end while (dma_done !== 1'b1 && n < 40 * CYC);
				if (i == k - 2)
					dma_req = 1'b0;
			end
		end
	endtask : dma_run

	// ****
	// Clock, monitor, sequence
	// ****
	initial
	begin
		forever #2 clk = ~clk;
	end

	always @(posedge clk) clk_cnt++;

	always @(negedge clk)
	begin
		if (rd_valid === 1'b1)
		begin
			check({8'h00, rd_data}, {8'h00, rq.pop_front()});
			check({15'h0000, stalled}, 16'h0000);
		end
		if (dma_done === 1'b1)
		begin
			check({8'h00, dma_rdata}, {8'h00, dq.pop_front()});
			// Grant stays only while more transfers of this burst are due
			check({15'h0000, dma_grant}, {15'h0000, dq.size() != 0});
			check({15'h0000, stalled}, 16'h0001);
		end
		if (bus.cyc_end === 1'b1 && bus.cpu_rw === `RW_WRITE) check({8'h00, bus.data_bus}, {8'h00, wq.pop_front()});
		if (refreshing === 1'b1)
		begin
			check(bus.mem_addr, {11'h000, exp_row});
			check({11'h000, row}, {11'h000, exp_row});
			check({15'h0000, bus.bus_free}, 16'h0001);
			check({15'h0000, bus.mem_rw}, {15'h0000, `RW_READ});
			// Tolerates either reading of the wrap point, one refresh per 64 cycles
			if (!ref_prev) check(16'((cyc_cnt + 1) / 64), 16'(n_ref + 1));
		end
		if (ref_prev && refreshing !== 1'b1)
		begin
			n_ref++;
			exp_row++;
		end
		ref_prev = (refreshing === 1'b1);
		if (bus.cyc_end === 1'b1) cyc_cnt++;
	end

	initial
	begin
		#300000;
		check(16'h0000, 16'h0001);
		test_done();
	end

	initial
	begin
		int t0, t1, t2, t3, t4, n;
		void'($urandom(51434));
		rq.push_back(mem_f(16'h0000));
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		cpu_acc(16'h1234, 1'b0, 1'b0, t0);
		cpu_acc(16'he010, 1'b0, 1'b0, t1);
		cpu_acc(16'h0040, 1'b1, 1'b0, t2);
		cpu_acc(16'h0041, 1'b0, 1'b1, t3);
		cpu_acc(16'h0042, 1'b1, 1'b0, t4);
		check(16'(t1 - t0), 16'(CYC));
		check(16'(t2 - t1), 16'(2 * CYC));
		check(16'(t3 - t2), 16'(CYC));
		check(16'(t4 - t3), 16'(2 * CYC));
		fork
			cpu_run();
			dma_run();
		join
		n = 0;
		while (rq.size() + wq.size() + dq.size() > 0 && n < 8 * CYC)
		begin
			@(negedge clk);
			n++;
		end
		check(16'(rq.size() + wq.size() + dq.size()), 16'h0000);
		test_done();
	end
endmodule : test_cpu_stall_memory_takeover
